// file: src/sacs_defines.svh
`ifndef SACS_DEFINES_SVH
`define SACS_DEFINES_SVH

// register byte offsets on the APB bus
`define SACS_ADDR_CMD 8'h00
`define SACS_ADDR_STATUS 8'h04
`define SACS_ADDR_DATA16 8'h08
`define SACS_ADDR_DATA32 8'h0c
`define SACS_ADDR_POP 8'h10

// command opcodes, low seven bits of the command byte
`define SACS_OP_DUP16 7'h77
`define SACS_OP_PUSHPI 7'h1a
`define SACS_OP_EXPO 7'h0b
`define SACS_OP_ADD 7'h6c
`define SACS_OP_SUB 7'h6d
`define SACS_OP_MULLO 7'h6e
`define SACS_OP_MULHI 7'h76
`define SACS_OP_DIV 7'h6f
`define SACS_OP_SINE 7'h02
`define SACS_OP_ROOT 7'h01
`define SACS_SVC_BIT 7

// execution times in clock cycles
`define SACS_CYC_DUP16 14'h0010
`define SACS_CYC_PUSHPI 14'h0010
`define SACS_CYC_EXPO 14'h2062
`define SACS_CYC_ADD 14'h0011
`define SACS_CYC_SUB 14'h001e
`define SACS_CYC_MULLO 14'h0054
`define SACS_CYC_MULHI 14'h0050
`define SACS_CYC_DIV 14'h005a
`define SACS_CYC_SINE 14'h0bb8
`define SACS_CYC_ROOT 14'h030e

// error field codes
`define SACS_ERR_NONE 4'h0
`define SACS_ERR_NEG 4'h4
`define SACS_ERR_RANGE 4'hc
`define SACS_ERR_DIV0 4'h8
`define SACS_ERR_OVF 4'h6

// reset values
`define SACS_RST_PTR 3'h0
`define SACS_RST_STATE '0

// numeric constants, fixed point values are Q31.32
`define SACS_PI_F32 32'h40490fdb
`define SACS_FX_ONE 64'h0000_0001_0000_0000
`define SACS_FX_HALF 64'h0000_0000_8000_0000
`define SACS_FX_32 64'h0000_0020_0000_0000
`define SACS_FX_LN2 64'h0000_0000_b172_17f8
`define SACS_FX_INVPI 64'h0000_0000_517c_c1b7
`define SACS_FX_PI 64'h0000_0003_243f_6a89
`define SACS_MIN16 16'h8000

`endif

// file: src/sacs_pkg.sv
package sacs_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sacs_apb_req_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } sacs_apb_rsp_type;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'h0,
    ENG_LOG = 3'h1,
    ENG_EXP = 3'h3,
    ENG_HOLD = 3'h2,
    ENG_ROOT = 3'h6,
    ENG_SINE = 3'h7
  } sacs_eng_type;

  typedef struct packed {
    logic [7:0][15:0] ent;
    logic [2:0] ptr;
    logic busy;
    logic [7:0] cmd;
    logic [13:0] cnt;
    logic sgnFlag;
    logic zeroFlag;
    logic [3:0] errCode;
    logic carryFlag;
    logic svc;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    sacs_eng_type eng;
    logic [4:0] iter;
    logic satFlag;
    logic [15:0] expo;
    logic [63:0] xa;
    logic [63:0] xb;
    logic [63:0] acc;
    logic [31:0] res32;
    logic [3:0] resErr;
  } sacs_state_type;

endpackage

// file: src/sacs_core.sv
// Summary of operation
// - dup_top16_cmd pushes 16-bit stack down, copying old top; takes 16 cycles.
// - push_pi_cmd pushes 32-bit stack down, loads pi into top; 16 cycles.
// - service request bit set drives request output at completion, else it stays low.
// - exponent_cmd raises second to power of top, result replaces second, stack up.
// - exponent_cmd with zero or negative base reports error code 0100.
// - exponent_cmd with exponent times ln base beyond plus/minus 32 reports 1100.
// - int16_add_cmd adds top to second, sum replaces second, stack moves up.
// - add sets carry on carry out; signed overflow flagged, low 16 bits kept.
// - int16_div_cmd divides second by top, quotient only replaces second, stack up.
// - divide by zero returns dividend unchanged and reports divide-by-zero error.
// - trig_y_cmd replaces top with sine, range-reduced into minus to plus pi/2.
// - int16_mul_low_cmd keeps low product half; overflow if upper half non-zero.
// - int16_mul_high_cmd keeps upper product half, stack moves up; 80 to 98 cycles.
// - either multiply with most negative operand returns that value and sets overflow.
// - root_cmd replaces top with its square root; 782 to 870 cycles.
// - root_cmd on a negative operand reports error code 0100.
// - int16_sub_cmd subtracts top from second, stack up, borrow shown as carry.
// - subtract overflows on most negative subtrahend or unrepresentable difference.
// - every command updates sign and zero; add/sub carry; arithmetic except sine the error field.
`timescale 1ns/10ps
`include "sacs_defines.svh"

module sacs_core #(
  parameter logic [13:0] EXPO_CYCLES = `SACS_CYC_EXPO
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire sacs_pkg::sacs_apb_req_type apbReq, // apb request
  output sacs_pkg::sacs_apb_rsp_type apbRsp, // apb answer
  output logic busy, // command in progress
  output logic svcReq // service request
);
  import sacs_pkg::*;

  sacs_state_type q;
  sacs_state_type n;

  logic [15:0] top16;
  logic [15:0] nos16;
  logic [31:0] top32;
  logic [31:0] nos32;
  logic apbDone;
  logic [6:0] op;
  logic [15:0] r16;
  logic ovf;
  logic [16:0] sum17;
  logic [31:0] prod32;
  logic [64:0] ext;
  logic [63:0] tmp;
  logic [63:0] zt;
  logic [63:0] yt;
  logic [63:0] lfull;
  logic [95:0] prod96;

  function automatic logic [63:0] fxmul(input logic [63:0] a, input logic [63:0] b);
    logic signed [127:0] p;
    p = $signed(a) * $signed(b);
    return p[95:32];
  endfunction

  function automatic logic [63:0] recip(input logic [3:0] k);
    case (k)
      4'h1: return 64'h0000_0001_0000_0000;
      4'h2: return 64'h0000_0000_8000_0000;
      4'h3: return 64'h0000_0000_5555_5555;
      4'h4: return 64'h0000_0000_4000_0000;
      4'h5: return 64'h0000_0000_3333_3333;
      4'h6: return 64'h0000_0000_2aaa_aaab;
      4'h7: return 64'h0000_0000_2492_4925;
      4'h8: return 64'h0000_0000_2000_0000;
      4'h9: return 64'h0000_0000_1c71_c71c;
      4'ha: return 64'h0000_0000_1999_999a;
      4'hb: return 64'h0000_0000_1745_d174;
      default: return 64'h0;
    endcase
  endfunction

  // saturates at 2^23 so later products stay inside Q31.32
  function automatic logic [64:0] f2fx(input logic [31:0] f);
    logic signed [9:0] sh;
    logic [63:0] m;
    logic sat;
    sat = 1'b0;
    sh = $signed({2'b00, f[30:23]}) - 10'sh076;
    m = {40'h0, 1'b1, f[22:0]};
    if (f[30:23] == 8'h00) begin
      m = '0;
    end else if (sh > 10'sh01f) begin
      sat = 1'b1;
      m = 64'h0000_7fff_ffff_ffff;
    end else if (sh >= 10'sh000) begin
      m = m << sh[5:0];
    end else begin
      m = m >> (10'sh000 - sh);
    end
    return {sat, f[31] ? (64'h0 - m) : m};
  endfunction

  // truncating conversion, no rounding
  function automatic logic [31:0] fx2f(input logic [63:0] x);
    logic [63:0] a;
    logic [5:0] p;
    a = x[63] ? (64'h0 - x) : x;
    p = '0;
    for (int i = 0; i < 64; i++) begin
      if (a[i]) begin
        p = i[5:0];
      end
    end
    a = a << (6'h3f - p);
    if (x == 64'h0) begin
      return 32'h0;
    end
    return {x[63], 8'({2'b00, p}) + 8'h5f, a[62:40]};
  endfunction

  function automatic logic [13:0] cycles(input logic [6:0] o);
    case (o)
      `SACS_OP_DUP16: return `SACS_CYC_DUP16;
      `SACS_OP_PUSHPI: return `SACS_CYC_PUSHPI;
      `SACS_OP_EXPO: return EXPO_CYCLES;
      `SACS_OP_ADD: return `SACS_CYC_ADD;
      `SACS_OP_SUB: return `SACS_CYC_SUB;
      `SACS_OP_MULLO: return `SACS_CYC_MULLO;
      `SACS_OP_MULHI: return `SACS_CYC_MULHI;
      `SACS_OP_DIV: return `SACS_CYC_DIV;
      `SACS_OP_SINE: return `SACS_CYC_SINE;
      `SACS_OP_ROOT: return `SACS_CYC_ROOT;
      default: return 14'h0000;
    endcase
  endfunction

  function automatic logic isCtlAddr(input logic [7:0] a);
    return a == `SACS_ADDR_CMD || a == `SACS_ADDR_DATA16 || a == `SACS_ADDR_DATA32 || a == `SACS_ADDR_POP;
  endfunction

  // both views share entry ptr as top; 32-bit top is {ent[ptr], ent[ptr+1]}
  assign top16 = q.ent[q.ptr];
  assign nos16 = q.ent[q.ptr + 3'h1];
  assign top32 = {q.ent[q.ptr], q.ent[q.ptr + 3'h1]};
  assign nos32 = {q.ent[q.ptr + 3'h2], q.ent[q.ptr + 3'h3]};
  assign apbDone = apbReq.psel & apbReq.penable & q.pready;
  assign op = q.cmd[6:0];

  always_comb begin
    n = q;
    r16 = '0;
    ovf = 1'b0;
    sum17 = '0;
    prod32 = '0;
    ext = '0;
    tmp = '0;
    zt = '0;
    yt = '0;
    lfull = '0;
    prod96 = '0;

    // one wait state: pready and read data come from flops
    n.pready = apbReq.psel & apbReq.penable & ~q.pready;
    n.pslverr = 1'b0;
    if (apbReq.psel && apbReq.penable && !q.pready) begin
      n.prdata = '0;
      unique case (apbReq.paddr)
        `SACS_ADDR_CMD: n.prdata = {24'h0, q.cmd};
        `SACS_ADDR_STATUS: n.prdata = {24'h0, q.busy, q.sgnFlag, q.zeroFlag, q.errCode, q.carryFlag};
        `SACS_ADDR_DATA16: n.prdata = {16'h0, top16};
        `SACS_ADDR_DATA32: n.prdata = top32;
        `SACS_ADDR_POP: n.prdata = '0;
        default: n.pslverr = 1'b1;
      endcase
      // stack and command are frozen while a command runs
      if (apbReq.pwrite && q.busy && isCtlAddr(apbReq.paddr)) begin
        n.pslverr = 1'b1;
      end
    end

    if (apbDone && apbReq.pwrite && !q.pslverr) begin
      unique case (apbReq.paddr)
        `SACS_ADDR_CMD: begin
          n.cmd = apbReq.pwdata[7:0];
          n.svc = 1'b0;
          n.cnt = '0;
          n.busy = cycles(apbReq.pwdata[6:0]) != 14'h0000;
          n.resErr = `SACS_ERR_NONE;
          n.eng = ENG_HOLD;
          n.acc = '0;
          if (apbReq.pwdata[6:0] == `SACS_OP_ROOT) begin
            n.res32 = top32;
            if (top32[30:23] == 8'h00) begin
              n.res32 = '0;
            end else if (top32[31]) begin
              n.resErr = `SACS_ERR_NEG;
            end else begin
              n.expo = (({8'h00, top32[30:23]} + 16'h0001) >> 1) + 16'h003f;
              n.xb = top32[23] ? {16'h0, 2'b01, top32[22:0], 23'h0} : {16'h0, 1'b1, top32[22:0], 24'h0};
              n.iter = 5'h17;
              n.eng = ENG_ROOT;
            end
          end else if (apbReq.pwdata[6:0] == `SACS_OP_EXPO) begin
            if (nos32[31] || nos32[30:23] == 8'h00) begin
              n.resErr = `SACS_ERR_NEG;
              n.res32 = nos32;
            end else begin
              ext = f2fx(top32);
              n.satFlag = ext[64];
              n.xa = ext[63:0];
              n.xb = {31'h0, 1'b1, nos32[22:0], 9'h0};
              n.expo = {8'h00, nos32[30:23]} - 16'h007f;
              n.iter = '0;
              n.eng = ENG_LOG;
            end
          end else if (apbReq.pwdata[6:0] == `SACS_OP_SINE) begin
            // inputs beyond 2^23 saturate, so their sine is meaningless
            ext = f2fx(top32);
            tmp = fxmul(ext[63:0], `SACS_FX_INVPI) + `SACS_FX_HALF;
            prod96 = $signed(tmp[63:32]) * $signed(`SACS_FX_PI);
            n.xa = ext[63:0] - prod96[63:0];
            n.xb = fxmul(n.xa, n.xa);
            n.expo = {15'h0, tmp[32]};
            n.acc = `SACS_FX_ONE;
            n.iter = 5'h0b;
            n.eng = ENG_SINE;
          end
        end
        `SACS_ADDR_DATA16: begin
          n.ptr = q.ptr - 3'h1;
          n.ent[q.ptr - 3'h1] = apbReq.pwdata[15:0];
        end
        `SACS_ADDR_DATA32: begin
          n.ptr = q.ptr - 3'h2;
          n.ent[q.ptr - 3'h2] = apbReq.pwdata[31:16];
          n.ent[q.ptr - 3'h1] = apbReq.pwdata[15:0];
        end
        `SACS_ADDR_POP: begin
          n.ptr = q.ptr + (apbReq.pwdata[0] ? 3'h2 : 3'h1);
        end
        default: begin
        end
      endcase
    end

    // iterative engine, always far quicker than the documented counts
    unique case (q.eng)
      ENG_IDLE, ENG_HOLD: begin
      end
      ENG_ROOT: begin
        tmp = q.acc | (64'h1 << q.iter);
        if (tmp[31:0] * tmp[31:0] <= q.xb) begin
          n.acc = tmp;
        end
        n.iter = q.iter - 5'h01;
        if (q.iter == 5'h00) begin
          n.res32 = {1'b0, q.expo[7:0], n.acc[22:0]};
          n.eng = ENG_HOLD;
        end
      end
      ENG_LOG: begin
        if (q.iter != 5'h18) begin
          tmp = fxmul(q.xb, q.xb);
          n.xb = tmp[33] ? (tmp >> 1) : tmp;
          if (tmp[33]) begin
            n.acc = q.acc | (64'h0000_0000_8000_0000 >> q.iter);
          end
          n.iter = q.iter + 5'h01;
        end else begin
          lfull = {{16{q.expo[15]}}, q.expo, q.acc[31:0]};
          zt = fxmul(q.xa, lfull);
          yt = fxmul(zt, `SACS_FX_LN2);
          tmp = yt[63] ? (64'h0 - yt) : yt;
          if ((q.satFlag && lfull != 64'h0) || tmp > `SACS_FX_32) begin
            n.resErr = `SACS_ERR_RANGE;
            n.res32 = '0;
            n.eng = ENG_HOLD;
          end else begin
            n.expo = zt[47:32];
            n.xa = fxmul({32'h0, zt[31:0]}, `SACS_FX_LN2);
            n.acc = `SACS_FX_ONE;
            n.iter = 5'h0a;
            n.eng = ENG_EXP;
          end
        end
      end
      ENG_EXP: begin
        if (q.iter != 5'h00) begin
          n.acc = `SACS_FX_ONE + fxmul(fxmul(q.xa, q.acc), recip(q.iter[3:0]));
          n.iter = q.iter - 5'h01;
        end else begin
          tmp = {48'h0, q.expo + 16'h007f};
          n.res32 = {1'b0, tmp[7:0], q.acc[31:9]};
          n.eng = ENG_HOLD;
        end
      end
      ENG_SINE: begin
        if (q.iter > 5'h01) begin
          tmp = fxmul(recip(q.iter[3:0]), recip(q.iter[3:0] - 4'h1));
          n.acc = `SACS_FX_ONE - fxmul(fxmul(q.xb, q.acc), tmp);
          n.iter = q.iter - 5'h02;
        end else begin
          tmp = fxmul(q.xa, q.acc);
          n.res32 = fx2f(q.expo[0] ? (64'h0 - tmp) : tmp);
          n.eng = ENG_HOLD;
        end
      end
      default: n.eng = ENG_IDLE;
    endcase

    // completion: command results reach the stack and the flags only here
    if (q.busy) begin
      n.cnt = q.cnt + 14'h0001;
      if (q.cnt == cycles(op) - 14'h0001) begin
        n.busy = 1'b0;
        n.eng = ENG_IDLE;
        n.svc = q.cmd[`SACS_SVC_BIT];
        unique case (op)
          `SACS_OP_DUP16: begin
            n.ptr = q.ptr - 3'h1;
            n.ent[q.ptr - 3'h1] = top16;
            n.sgnFlag = top16[15];
            n.zeroFlag = top16 == 16'h0;
          end
          `SACS_OP_PUSHPI: begin
            n.ptr = q.ptr - 3'h2;
            n.ent[q.ptr - 3'h2] = 16'(`SACS_PI_F32 >> 16);
            n.ent[q.ptr - 3'h1] = 16'(`SACS_PI_F32);
            n.sgnFlag = 1'b0;
            n.zeroFlag = 1'b0;
          end
          `SACS_OP_EXPO, `SACS_OP_SINE, `SACS_OP_ROOT: begin
            if (op == `SACS_OP_EXPO) begin
              n.ptr = q.ptr + 3'h2;
              n.ent[q.ptr + 3'h2] = q.res32[31:16];
              n.ent[q.ptr + 3'h3] = q.res32[15:0];
            end else begin
              n.ent[q.ptr] = q.res32[31:16];
              n.ent[q.ptr + 3'h1] = q.res32[15:0];
            end
            if (op != `SACS_OP_SINE) begin
              n.errCode = q.resErr;
            end
            n.sgnFlag = q.res32[31];
            n.zeroFlag = q.res32[30:23] == 8'h00;
          end
          default: begin
            // 16-bit integer group
            n.errCode = `SACS_ERR_NONE;
            prod32 = $signed(top16) * $signed(nos16);
            if (op == `SACS_OP_ADD) begin
              sum17 = {1'b0, nos16} + {1'b0, top16};
              r16 = sum17[15:0];
              n.carryFlag = sum17[16];
              ovf = top16[15] == nos16[15] && r16[15] != top16[15];
            end else if (op == `SACS_OP_SUB) begin
              sum17 = {1'b0, nos16} - {1'b0, top16};
              r16 = sum17[15:0];
              n.carryFlag = sum17[16];
              ovf = top16 == `SACS_MIN16 || (top16[15] != nos16[15] && r16[15] != nos16[15]);
            end else if (op == `SACS_OP_DIV) begin
              if (top16 == 16'h0) begin
                r16 = nos16;
                n.errCode = `SACS_ERR_DIV0;
              end else if (nos16 == `SACS_MIN16 && top16 == 16'hffff) begin
                r16 = `SACS_MIN16;
                ovf = 1'b1;
              end else begin
                r16 = 16'($signed(nos16) / $signed(top16));
              end
            end else begin
              r16 = (op == `SACS_OP_MULLO) ? prod32[15:0] : prod32[31:16];
              ovf = op == `SACS_OP_MULLO && prod32[31:16] != 16'h0;
              if (top16 == `SACS_MIN16 || nos16 == `SACS_MIN16) begin
                r16 = `SACS_MIN16;
                ovf = 1'b1;
              end
            end
            if (ovf) begin
              n.errCode = `SACS_ERR_OVF;
            end
            n.ptr = q.ptr + 3'h1;
            n.ent[q.ptr + 3'h1] = r16;
            n.sgnFlag = r16[15];
            n.zeroFlag = r16 == 16'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= `SACS_RST_STATE;
      q.ptr <= `SACS_RST_PTR;
    end else begin
      q <= n;
    end
  end

  assign apbRsp = '{pready: q.pready, prdata: q.prdata, pslverr: q.pslverr};
  assign busy = q.busy;
  assign svcReq = q.svc;

endmodule

// file: tb/sacs_core_assertions.sv
`timescale 1ns/10ps
`include "sacs_defines.svh"
module sacs_core_assertions #(
  parameter logic [13:0] EXPO_CYCLES = 14'h0040
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire sacs_pkg::sacs_apb_req_type apbReq, // apb request
  input wire sacs_pkg::sacs_apb_rsp_type apbRsp, // apb answer
  input wire logic busy, // command in progress
  input wire logic svcReq // service request
);
  import sacs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [13:0] runCnt_q;
  logic [13:0] expN_q;
  logic [7:0] cmd_q;
  logic accept;
  logic access1;
  assign access1 = apbReq.psel && apbReq.penable && !apbRsp.pready;
  assign accept = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite &&
    apbReq.paddr == `SACS_ADDR_CMD && !apbRsp.pslverr;
  function automatic logic [13:0] cyc(input logic [6:0] op);
    case (op)
      7'h77, 7'h1a: cyc = 14'h0010;
      7'h0b: cyc = EXPO_CYCLES;
      7'h6c: cyc = 14'h0011;
      7'h6d: cyc = 14'h001e;
      7'h6e: cyc = 14'h0054;
      7'h76: cyc = 14'h0050;
      7'h6f: cyc = 14'h005a;
      7'h02: cyc = 14'h0bb8;
      7'h01: cyc = 14'h030e;
      default: cyc = 14'h0000;
    endcase
  endfunction
  // run length counted here since a repetition cannot hold thousands of cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      runCnt_q <= '0;
      expN_q <= '0;
      cmd_q <= '0;
    end else begin
      runCnt_q <= busy ? runCnt_q + 14'h0001 : 14'h0000;
      if (accept) begin
        expN_q <= cyc(apbReq.pwdata[6:0]);
        cmd_q <= apbReq.pwdata[7:0];
      end
    end
  end
  sequence cmdKnown;
    accept && cyc(apbReq.pwdata[6:0]) != 14'h0000;
  endsequence
  sequence cmdUnknown;
    accept && cyc(apbReq.pwdata[6:0]) == 14'h0000;
  endsequence
  sequence runDone;
    $fell(busy);
  endsequence
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready longer than one cycle");
  a_ready_answer: assert property (access1 |=> apbRsp.pready)
    else $error("pready missing after first access cycle");
  a_ready_cause: assert property (apbRsp.pready |-> $past(apbReq.psel && apbReq.penable))
    else $error("pready without access");
  a_busy_refused: assert property (
    access1 && apbReq.pwrite && busy && apbReq.paddr != `SACS_ADDR_STATUS |=> apbRsp.pslverr)
    else $error("write during command not refused");
  a_unmapped_err: assert property (access1 && (apbReq.paddr > 8'h10 || apbReq.paddr[1:0] != 2'h0)
    |=> apbRsp.pslverr) else $error("unmapped access not refused");
  a_cmd_start: assert property (cmdKnown |=> busy && !svcReq)
    else $error("command did not start");
  a_unknown_idle: assert property (cmdUnknown |=> !busy)
    else $error("unknown opcode started a run");
  a_busy_cause: assert property ($rose(busy) |-> $past(accept))
    else $error("busy rose without a command");
  a_run_length: assert property (runDone |-> runCnt_q == expN_q)
    else $error("command run length wrong");
  a_svc_done: assert property (runDone |-> svcReq == cmd_q[7])
    else $error("service request wrong at completion");
  a_svc_steady: assert property (!busy && !accept |=> $stable(svcReq))
    else $error("service request changed while idle");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !busy && !svcReq && !apbRsp.pready)
    else $error("outputs active after reset");
endmodule

// file: tb/sacs_host_model.sv
`timescale 1ns/10ps
module sacs_host_model (
  input wire logic clk_sys, // system clock
  output sacs_pkg::sacs_apb_req_type apbReq, // request to the block
  input wire sacs_pkg::sacs_apb_rsp_type apbRsp // answer from the block
);
  import sacs_pkg::*;
  initial apbReq = '0;
  // one apb transfer; only the bench watchdog ends a hung wait
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] v,
    output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= v;
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    // released lines show garbage, not the last value
    apbReq.paddr <= ~a;
    apbReq.pwdata <= ~v;
  endtask
  task automatic send_cmd(input logic svc, input logic [6:0] op, output logic err);
    logic [31:0] rd;
    xfer(1'b1, 8'h00, {24'h0, svc, op}, rd, err);
  endtask
endmodule

// file: tb/stack_arith_command_subset_tb.sv
`timescale 1ns/10ps
`include "sacs_defines.svh"
module stack_arith_command_subset_tb;
  import sacs_pkg::*;
  logic clk_sys;
  logic rst;
  sacs_apb_req_type apbReq;
  sacs_apb_rsp_type apbRsp;
  logic busy;
  logic svcReq;
  logic [31:0] d;
  logic e;
  int fails;
  int comparisons;
  sacs_core #(.EXPO_CYCLES(14'h0040)) u_sacs_core (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .busy(busy), .svcReq(svcReq));
  sacs_host_model u_sacs_host_model (.clk_sys(clk_sys), .apbReq(apbReq), .apbRsp(apbRsp));
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("%0d mismatches in %0d comparisons", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_sacs_host_model.xfer(1'b1, a, v, d, e);
  endtask
  task automatic rd(input logic [7:0] a);
    u_sacs_host_model.xfer(1'b0, a, 32'h0, d, e);
  endtask
  task automatic wait_done(input logic svc);
    @(posedge clk_sys);
    while (busy === 1'b1) @(posedge clk_sys);
    cmp_flag(svcReq, svc);
  endtask
  // push sentinel, second and top; run; check top, status and the entry below
  task automatic do_op(input logic w, input logic [31:0] b, input logic [31:0] a, input logic svc,
    input logic [6:0] op, input logic [31:0] expTop, input logic [31:0] expNext,
    input logic [7:0] st, input logic [7:0] m);
    logic [7:0] da;
    logic [31:0] vm;
    da = w ? `SACS_ADDR_DATA32 : `SACS_ADDR_DATA16;
    vm = w ? 32'hffffffff : 32'h0000ffff;
    wr(da, 32'h5a5aa5a5);
    wr(da, b);
    wr(da, a);
    u_sacs_host_model.send_cmd(svc, op, e);
    wait_done(svc);
    rd(da);
    cmp(d & vm, expTop);
    rd(`SACS_ADDR_STATUS);
    cmp({24'h0, d[7:0] & m}, {24'h0, st & m});
    wr(`SACS_ADDR_POP, {31'h0, w});
    rd(da);
    cmp(d & vm, expNext);
  endtask
  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`SACS_ADDR_STATUS);
    cmp(d, 32'h0);
    do_op(0, 32'h7fff, 32'h0001, 1, 7'h6c, 32'h8000, 32'ha5a5, 8'h4c, 8'h7f);
    do_op(0, 32'hffff, 32'h0001, 0, 7'h6c, 32'h0000, 32'ha5a5, 8'h21, 8'h7f);
    do_op(0, 32'h0000, 32'h0001, 1, 7'h6d, 32'hffff, 32'ha5a5, 8'h41, 8'h7f);
    do_op(0, 32'h0005, 32'h8000, 0, 7'h6d, 32'h8005, 32'ha5a5, 8'h4d, 8'h7f);
    do_op(0, 32'h8000, 32'h0001, 0, 7'h6d, 32'h7fff, 32'ha5a5, 8'h0c, 8'h7f);
    do_op(0, 32'h0007, 32'hfffe, 1, 7'h6f, 32'hfffd, 32'ha5a5, 8'h40, 8'h7e);
    do_op(0, 32'h1234, 32'h0000, 0, 7'h6f, 32'h1234, 32'ha5a5, 8'h10, 8'h7e);
    do_op(0, 32'h0100, 32'h0100, 0, 7'h6e, 32'h0000, 32'ha5a5, 8'h2c, 8'h7e);
    do_op(0, 32'h8000, 32'h0003, 1, 7'h6e, 32'h8000, 32'ha5a5, 8'h4c, 8'h7e);
    do_op(0, 32'h4000, 32'h0004, 0, 7'h76, 32'h0001, 32'ha5a5, 8'h00, 8'h7e);
    do_op(0, 32'h0005, 32'h8000, 1, 7'h76, 32'h8000, 32'ha5a5, 8'h4c, 8'h7e);
    do_op(0, 32'h1111, 32'h9abc, 1, 7'h77, 32'h9abc, 32'h9abc, 8'h40, 8'h60);
    do_op(1, 32'h11111111, 32'h3f800000, 1, 7'h1a, 32'h40490fdb, 32'h3f800000, 8'h00, 8'h60);
    do_op(1, 32'h11111111, 32'h40800000, 1, 7'h01, 32'h40000000, 32'h11111111, 8'h00, 8'h7e);
    do_op(1, 32'h11111111, 32'hc0800000, 0, 7'h01, 32'hc0800000, 32'h11111111, 8'h48, 8'h7e);
    do_op(1, 32'h11111111, 32'h00000000, 1, 7'h02, 32'h00000000, 32'h11111111, 8'h20, 8'h60);
    do_op(1, 32'h3f800000, 32'h40a00000, 1, 7'h0b, 32'h3f800000, 32'h5a5aa5a5, 8'h00, 8'h7e);
    do_op(1, 32'hc0000000, 32'h3f800000, 0, 7'h0b, 32'hc0000000, 32'h5a5aa5a5, 8'h48, 8'h7e);
    do_op(1, 32'h00000000, 32'h3f800000, 0, 7'h0b, 32'h00000000, 32'h5a5aa5a5, 8'h28, 8'h7e);
    do_op(1, 32'h40000000, 32'h42c80000, 0, 7'h0b, 32'h00000000, 32'h5a5aa5a5, 8'h38, 8'h7e);
    // refusals and commit point during a running command, then unmapped read and unknown opcode
    wr(`SACS_ADDR_DATA16, 32'h0003);
    wr(`SACS_ADDR_DATA16, 32'h0004);
    u_sacs_host_model.send_cmd(1'b0, 7'h6d, e);
    wr(`SACS_ADDR_DATA16, 32'h0009);
    cmp_flag(e, 1'b1);
    rd(`SACS_ADDR_DATA16);
    cmp({16'h0, d[15:0]}, 32'h0004);
    rd(`SACS_ADDR_STATUS);
    cmp_flag(d[7], 1'b1);
    wait_done(1'b0);
    rd(`SACS_ADDR_DATA16);
    cmp({16'h0, d[15:0]}, 32'hffff);
    rd(8'h14);
    cmp_flag(e, 1'b1);
    wr(`SACS_ADDR_STATUS, 32'hff);
    cmp_flag(e, 1'b0);
    u_sacs_host_model.send_cmd(1'b1, 7'h7f, e);
    wait_done(1'b0);
    rd(`SACS_ADDR_CMD);
    cmp({24'h0, d[7:0]}, 32'h000000ff);
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
endmodule
bind sacs_core sacs_core_assertions #(.EXPO_CYCLES(EXPO_CYCLES)) u_sacs_core_assertions (
  .clk_sys(clk_sys), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .busy(busy), .svcReq(svcReq));
